// ==== src/isf_map.svh ====
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH

// Register byte offsets (low address byte)
`define ISF_OFS_STATUS   8'h00
`define ISF_OFS_CTRL     8'h04
`define ISF_OFS_COUNT    8'h08
`define ISF_OFS_RXHOLD   8'h0C
`define ISF_OFS_ISRC     8'h10
`define ISF_OFS_IRQST    8'h14
`define ISF_OFS_IRQMASK  8'h18

// Status flag positions, shared by status, irq status and irq mask
`define ISF_BIT_NACK     1
`define ISF_BIT_ACCESS_READY_FLAG     2
`define ISF_BIT_RECEIVE_READY_FLAG     3

// Control field positions
`define ISF_CTL_REPEAT   0
`define ISF_CTL_STOP     1
`define ISF_CTL_MASTER   2
`define ISF_CTL_FIFO     3
`define ISF_CTL_XMIT     4
`define ISF_CTL_GO       5

// Reset values
`define ISF_RST_CTRL     5'h00
`define ISF_RST_COUNT    16'h0000
`define ISF_RST_MASK     3'h0

// Interrupt source codes
`define ISF_CODE_NONE    3'h0
`define ISF_CODE_NACK    3'h2
`define ISF_CODE_ACCESS_READY_FLAG    3'h3
`define ISF_CODE_RECEIVE_READY_FLAG    3'h4

// Bits per byte on the serial bus, ninth clock carries the acknowledge
`define ISF_BITS_BYTE    4'h8

`endif

// ==== src/isf_pkg.sv ====
package isf_pkg;

  // Serial bus phase, one-hot
  typedef enum logic [2:0] {
    ISF_PH_IDLE = 3'b001,
    ISF_PH_DATA = 3'b010,
    ISF_PH_ACK  = 3'b100
  } isf_phase_t;

  // Register selector decoded from the bus address
  typedef enum logic [2:0] {
    ISF_REG_STATUS,
    ISF_REG_CTRL,
    ISF_REG_COUNT,
    ISF_REG_RXHOLD,
    ISF_REG_ISRC,
    ISF_REG_IRQST,
    ISF_REG_IRQMASK,
    ISF_REG_NONE
  } isf_reg_t;

endpackage

// ==== src/isf_sync.sv ====
`timescale 1ns/1ps

module isf_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // Two flops per line; the first is read only by the second
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      meta_q   <= '1;
      sync_out <= '1;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== src/isf_status.sv ====
// Decided for this implementation: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`include "isf_map.svh"

// Contract
// - Received byte moved sets receive ready, non-FIFO
// - CPU holding read clears; debug read does not
// - Writing one clears receive ready flag
// - Module reset clears receive and access ready
// - Access ready in master mode, registers consumed
// - Non-repeat, no stop: counter zero sets ready
// - Non-repeat with stop: issue STOP, flag untouched
// - Repeat mode: each transmitted byte sets ready
// - Starting to use registers clears access ready
// - Writing one clears access ready flag
// - Transmitter receiving no-acknowledge sets nack flag
// - Acknowledge received clears nack flag
// - Writing one clears nack flag
// - Flags pollable, each can raise interrupt
// - CPU source read with nack code clears
// - Module reset clears nack flag
module isf_status
  import isf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        scl_pin,
  input  wire logic        sda_pin,
  input  wire logic        debug_access,
  output logic             stop_issue,
  output logic             irq
);

  // Address decode, used for both address-phase reads and data-phase writes
  function automatic isf_reg_t reg_decode(input logic [7:0] ofs);
    unique case (ofs)
      `ISF_OFS_STATUS:  reg_decode = ISF_REG_STATUS;
      `ISF_OFS_CTRL:    reg_decode = ISF_REG_CTRL;
      `ISF_OFS_COUNT:   reg_decode = ISF_REG_COUNT;
      `ISF_OFS_RXHOLD:  reg_decode = ISF_REG_RXHOLD;
      `ISF_OFS_ISRC:    reg_decode = ISF_REG_ISRC;
      `ISF_OFS_IRQST:   reg_decode = ISF_REG_IRQST;
      `ISF_OFS_IRQMASK: reg_decode = ISF_REG_IRQMASK;
      default:          reg_decode = ISF_REG_NONE;
    endcase
  endfunction

  logic        rx_ready_q;
  logic        acc_ready_q;
  logic        nack_q;
  logic [4:0]  ctrl_q;
  logic [15:0] count_q;
  logic [15:0] byte_cnt_q;
  logic [7:0]  rx_hold_q;
  logic [7:0]  shift_q;
  logic [3:0]  bit_cnt_q;
  logic [2:0]  irq_st_q;
  logic [2:0]  irq_mask_q;
  logic        wr_pend_q;
  isf_reg_t    wr_reg_q;
  logic        go_q;
  logic        stop_issue_q;
  logic        hresp_q;
  logic [31:0] hrdata_q;
  isf_phase_t  phase_q;
  logic [1:0]  pins_sync;
  logic        scl_prev_q;
  logic        sda_prev_q;
  logic [2:0]  src_code;
  logic [31:0] rd_data;

  wire repeat_mode = ctrl_q[`ISF_CTL_REPEAT];
  wire stop_req    = ctrl_q[`ISF_CTL_STOP];
  wire master_mode = ctrl_q[`ISF_CTL_MASTER];
  wire fifo_mode   = ctrl_q[`ISF_CTL_FIFO];
  wire xmit_mode   = ctrl_q[`ISF_CTL_XMIT];

  // Synchronised bus lines: bit 1 is clock, bit 0 is data
  isf_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({scl_pin, sda_pin}),
    .sync_out (pins_sync)
  );

  wire scl_s    = pins_sync[1];
  wire sda_s    = pins_sync[0];
  wire scl_rise = scl_s & ~scl_prev_q;
  wire start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  wire byte_end = (phase_q == ISF_PH_ACK) & scl_rise;

  // Bus access qualifiers
  wire      acc_ok = hsel & hready & htrans[1];
  wire      rd_acc = acc_ok & ~hwrite;
  isf_reg_t rd_reg;
  assign rd_reg = reg_decode(haddr[7:0]);
  wire cpu_rd   = rd_acc & ~debug_access;
  wire rx_rd    = cpu_rd & (rd_reg == ISF_REG_RXHOLD);
  wire isrc_clr = cpu_rd & (rd_reg == ISF_REG_ISRC)
                  & (src_code == `ISF_CODE_NACK);
  wire irqst_rd = cpu_rd & (rd_reg == ISF_REG_IRQST);
  wire wr_stat  = wr_pend_q & (wr_reg_q == ISF_REG_STATUS);
  wire wr_ctrl  = wr_pend_q & (wr_reg_q == ISF_REG_CTRL);

  // Flag events
  wire rx_move  = byte_end & ~xmit_mode;
  wire receive_ready_flag_set = rx_move & ~fifo_mode;
  wire ack_ev   = byte_end & xmit_mode & ~sda_s;
  wire nack_ev  = byte_end & xmit_mode & sda_s;
  wire cnt_hit  = byte_end & master_mode & ~repeat_mode
                  & (byte_cnt_q == 16'h0001);
  wire access_ready_flag_set = (cnt_hit & ~stop_req)
                  | (byte_end & master_mode & repeat_mode & xmit_mode);
  wire [2:0] ev_vec = {receive_ready_flag_set, access_ready_flag_set, nack_ev};

  // Line history for edge and condition detection
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  // Byte framing on the serial bus
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_q   <= ISF_PH_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
    end else if (start_ev) begin
      phase_q   <= ISF_PH_DATA;
      bit_cnt_q <= 4'h0;
    end else if (stop_ev) begin
      phase_q   <= ISF_PH_IDLE;
    end else if (scl_rise) begin
      unique case (phase_q)
        ISF_PH_IDLE: begin
          phase_q <= ISF_PH_IDLE;
        end
        ISF_PH_DATA: begin
          shift_q   <= {shift_q[6:0], sda_s};
          bit_cnt_q <= bit_cnt_q + 4'h1;
          if (bit_cnt_q == `ISF_BITS_BYTE - 4'h1) begin
            phase_q <= ISF_PH_ACK;
          end
        end
        ISF_PH_ACK: begin
          phase_q   <= ISF_PH_DATA;
          bit_cnt_q <= 4'h0;
        end
        default: begin
          phase_q <= ISF_PH_IDLE;
        end
      endcase
    end
  end

  // Receive holding register takes the shifted byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_hold_q <= 8'h00;
    end else if (rx_move) begin
      rx_hold_q <= shift_q;
    end
  end

  // Receive ready flag, set wins over clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_ready_q <= 1'b0;
    end else if (receive_ready_flag_set) begin
      rx_ready_q <= 1'b1;
    end else if (rx_rd | (wr_stat & hwdata[`ISF_BIT_RECEIVE_READY_FLAG])) begin
      rx_ready_q <= 1'b0;
    end
  end

  // Access ready flag, meaningful only in master mode
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      acc_ready_q <= 1'b0;
    end else if (access_ready_flag_set) begin
      acc_ready_q <= 1'b1;
    end else if (go_q | (wr_stat & hwdata[`ISF_BIT_ACCESS_READY_FLAG])) begin
      acc_ready_q <= 1'b0;
    end
  end

  // No-acknowledge flag, tracks the last answer while transmitting
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      nack_q <= 1'b0;
    end else if (nack_ev) begin
      nack_q <= 1'b1;
    end else if (ack_ev | isrc_clr | (wr_stat & hwdata[`ISF_BIT_NACK])) begin
      nack_q <= 1'b0;
    end
  end

  // Control, count and mask registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl_q     <= `ISF_RST_CTRL;
      count_q    <= `ISF_RST_COUNT;
      irq_mask_q <= `ISF_RST_MASK;
    end else if (wr_pend_q) begin
      if (wr_reg_q == ISF_REG_CTRL) begin
        ctrl_q <= hwdata[4:0];
      end
      if (wr_reg_q == ISF_REG_COUNT) begin
        count_q <= hwdata[15:0];
      end
      if (wr_reg_q == ISF_REG_IRQMASK) begin
        irq_mask_q <= hwdata[3:1];
      end
    end
  end

  // Go strobe marks the moment programmed values are taken into use
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      go_q <= 1'b0;
    end else begin
      go_q <= wr_ctrl & hwdata[`ISF_CTL_GO];
    end
  end

  // Internal byte counter, loaded on go and counted down at each byte end in master mode until it reaches zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      byte_cnt_q <= 16'h0000;
    end else if (go_q) begin
      byte_cnt_q <= count_q;
    end else if (byte_end & master_mode & (byte_cnt_q != 16'h0000)) begin
      byte_cnt_q <= byte_cnt_q - 16'h0001;
    end
  end

  // STOP request towards the bus engine when the count runs out
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stop_issue_q <= 1'b0;
    end else begin
      stop_issue_q <= cnt_hit & stop_req;
    end
  end

  // Sticky interrupt status, cleared by a CPU read; set wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_st_q <= 3'h0;
    end else if (irqst_rd) begin
      irq_st_q <= ev_vec;
    end else begin
      irq_st_q <= irq_st_q | ev_vec;
    end
  end

  // Interrupt line, high while an unmasked status bit is set
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_st_q | ev_vec) & irq_mask_q
               & ~({3{irqst_rd}} & ~ev_vec));
    end
  end

  // Interrupt source code, nack first
  always_comb begin
    if (nack_q) begin
      src_code = `ISF_CODE_NACK;
    end else if (acc_ready_q) begin
      src_code = `ISF_CODE_ACCESS_READY_FLAG;
    end else if (rx_ready_q) begin
      src_code = `ISF_CODE_RECEIVE_READY_FLAG;
    end else begin
      src_code = `ISF_CODE_NONE;
    end
  end

  // Read mux; status read itself has no side effect
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (rd_reg)
      ISF_REG_STATUS: begin
        rd_data[`ISF_BIT_RECEIVE_READY_FLAG] = rx_ready_q;
        rd_data[`ISF_BIT_ACCESS_READY_FLAG] = acc_ready_q;
        rd_data[`ISF_BIT_NACK] = nack_q;
      end
      ISF_REG_CTRL:    rd_data[4:0]  = ctrl_q;
      ISF_REG_COUNT:   rd_data[15:0] = count_q;
      ISF_REG_RXHOLD:  rd_data[7:0]  = rx_hold_q;
      ISF_REG_ISRC:    rd_data[2:0]  = src_code;
      ISF_REG_IRQST:   rd_data[3:1]  = irq_st_q;
      ISF_REG_IRQMASK: rd_data[3:1]  = irq_mask_q;
      ISF_REG_NONE:    rd_data       = 32'h0000_0000;
    endcase
  end

  // Bus slave: read data latched in the address phase, write held over
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_reg_q  <= ISF_REG_NONE;
      hrdata_q  <= 32'h0000_0000;
      hresp_q   <= 1'b0;
    end else begin
      wr_pend_q <= acc_ok & hwrite;
      wr_reg_q  <= reg_decode(haddr[7:0]);
      hresp_q   <= 1'b0;
      if (rd_acc) begin
        hrdata_q <= rd_data;
      end
    end
  end

  assign hreadyout  = 1'b1;
  assign hresp      = hresp_q;
  assign hrdata     = hrdata_q;
  assign stop_issue = stop_issue_q;

  // Checks
  AST_RECEIVE_READY_FLAG_SET: assert property (@(posedge clk_sys) disable iff (reset)
    receive_ready_flag_set |=> rx_ready_q)
    else $error("receive ready not set after byte move");
  AST_RECEIVE_READY_FLAG_FIFO: assert property (@(posedge clk_sys) disable iff (reset)
    rx_move && fifo_mode && !rx_ready_q |=> !rx_ready_q)
    else $error("receive ready set in fifo mode");
  AST_RECEIVE_READY_FLAG_RD: assert property (@(posedge clk_sys) disable iff (reset)
    rx_rd && !receive_ready_flag_set |=> !rx_ready_q)
    else $error("receive ready not cleared by holding read");
  AST_RECEIVE_READY_FLAG_EMU: assert property (@(posedge clk_sys) disable iff (reset)
    rd_acc && debug_access && !wr_stat && !receive_ready_flag_set |=> $stable(rx_ready_q))
    else $error("debug read changed receive ready");
  AST_W1C: assert property (@(posedge clk_sys) disable iff (reset)
    wr_stat && hwdata[3] && hwdata[2] && hwdata[1] && ev_vec == 3'h0
    |=> !rx_ready_q && !acc_ready_q && !nack_q)
    else $error("write one did not clear flags");
  AST_W0: assert property (@(posedge clk_sys) disable iff (reset)
    wr_stat && hwdata[3:1] == 3'h0 && !go_q && !rx_rd && !isrc_clr && !ack_ev
    |=> rx_ready_q >= $past(rx_ready_q) && acc_ready_q >= $past(acc_ready_q)
        && nack_q >= $past(nack_q))
    else $error("write zero cleared a flag");
  AST_RESET: assert property (@(posedge clk_sys)
    reset |=> !rx_ready_q && !acc_ready_q && !nack_q && !irq)
    else $error("flags not cleared by reset");
  AST_ACCESS_READY_FLAG_CNT: assert property (@(posedge clk_sys) disable iff (reset)
    cnt_hit && !stop_req |=> acc_ready_q ##1 byte_cnt_q == 16'h0000 || go_q)
    else $error("access ready not set at count zero");
  AST_ACCESS_READY_FLAG_STP: assert property (@(posedge clk_sys) disable iff (reset)
    cnt_hit && stop_req
    |=> stop_issue && (acc_ready_q == $past(acc_ready_q) || $past(go_q)
        || $past(wr_stat)))
    else $error("stop not issued or access ready touched");
  AST_ACCESS_READY_FLAG_RM: assert property (@(posedge clk_sys) disable iff (reset)
    byte_end && master_mode && repeat_mode && xmit_mode |=> acc_ready_q)
    else $error("access ready not set in repeat mode");
  AST_ACCESS_READY_FLAG_GO: assert property (@(posedge clk_sys) disable iff (reset)
    wr_ctrl && hwdata[5] && !access_ready_flag_set ##1 !access_ready_flag_set |=> !acc_ready_q)
    else $error("access ready not cleared at go");
  AST_NACK: assert property (@(posedge clk_sys) disable iff (reset)
    nack_ev |=> nack_q && src_code == 3'h2)
    else $error("nack flag not set");
  AST_ACK: assert property (@(posedge clk_sys) disable iff (reset)
    ack_ev |=> !nack_q)
    else $error("nack flag not cleared by ack");
  AST_ISRC: assert property (@(posedge clk_sys) disable iff (reset)
    isrc_clr && !nack_ev |=> !nack_q)
    else $error("source read did not clear nack");
  AST_IRQ: assert property (@(posedge clk_sys) disable iff (reset)
    nack_ev && irq_mask_q[0] && !irqst_rd ##1 !irqst_rd |=> irq)
    else $error("interrupt not raised for nack");
  AST_STAT_RD: assert property (@(posedge clk_sys) disable iff (reset)
    rd_acc && rd_reg == ISF_REG_STATUS && ev_vec == 3'h0 && !wr_stat
    && !go_q && !ack_ev |=> $stable({rx_ready_q, acc_ready_q, nack_q}))
    else $error("status read changed a flag");

endmodule

// ==== sim/isf_bus_peer.sv ====
`timescale 1ns/1ps

module isf_bus_peer (
  output logic scl,
  output logic sda
);
  localparam int HALF = 80;

  // Idle bus: both lines rest at the pull-up level
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end

  // START, eight bits MSB first, acknowledge bit, then STOP
  task automatic frame(input logic [7:0] b, input logic ackb);
    logic [8:0] bits;
    bits = {b, ackb};
    // Start off the clock edge so the synchroniser never races a line change
    #5 sda = 1'b0;
    #HALF scl = 1'b0;
    for (int i = 8; i >= 0; i--) begin
      #(HALF/2) sda = bits[i];
      #(HALF/2) scl = 1'b1;
      #HALF scl = 1'b0;
    end
    #(HALF/2) sda = 1'b0;
    #(HALF/2) scl = 1'b1;
    #HALF sda = 1'b1;
    #HALF;
  endtask
endmodule

// ==== sim/isf_status_tb.sv ====
`timescale 1ns/1ps
`include "isf_map.svh"

module isf_status_tb;
  import isf_pkg::*;

  typedef struct packed {
    logic [4:0]  ctrl;
    logic [15:0] cnt;
    logic [7:0]  data;
    logic        ackb;
    logic [3:0]  stat;
    logic        stop_request_bit;
  } isf_row_t;

  logic        clk_sys;
  logic        reset;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        scl_pin;
  logic        sda_pin;
  logic        debug_access;
  logic        stop_issue;
  logic        irq;
  logic [31:0] junk;
  int          fail_count = 0;
  int          checks_done = 0;
  int          stop_seen = 0;
  int          s0;

  // Ordinary transfers: control, count, byte, ack bit, status, STOPs
  isf_row_t rows [9] = '{
    '{5'h00, 16'h0001, 8'hA5, 1'b0, 4'h8, 1'b0},
    '{5'h08, 16'h0001, 8'h5A, 1'b0, 4'h0, 1'b0},
    '{5'h14, 16'h0001, 8'h3C, 1'b0, 4'h4, 1'b0},
    '{5'h16, 16'h0001, 8'hC3, 1'b0, 4'h0, 1'b1},
    '{5'h15, 16'h0005, 8'h81, 1'b0, 4'h4, 1'b0},
    '{5'h14, 16'h0002, 8'h7E, 1'b0, 4'h0, 1'b0},
    '{5'h10, 16'h0001, 8'h0F, 1'b1, 4'h2, 1'b0},
    '{5'h04, 16'h0001, 8'hF0, 1'b0, 4'hC, 1'b0},
    '{5'h14, 16'h0001, 8'h11, 1'b1, 4'h6, 1'b0}
  };

  isf_bus_peer bus_peer (
    .scl (scl_pin),
    .sda (sda_pin)
  );

  isf_status u_isf_status (
    .clk_sys      (clk_sys),
    .reset        (reset),
    .hsel         (hsel),
    .haddr        (haddr),
    .htrans       (htrans),
    .hwrite       (hwrite),
    .hsize        (hsize),
    .hwdata       (hwdata),
    .hready       (hready),
    .hreadyout    (hreadyout),
    .hresp        (hresp),
    .hrdata       (hrdata),
    .scl_pin      (scl_pin),
    .sda_pin      (sda_pin),
    .debug_access (debug_access),
    .stop_issue   (stop_issue),
    .irq          (irq)
  );

  // Single slave: its ready is the bus ready
  assign hready = hreadyout;

  // 50 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Counts cycles with the STOP request high
  always @(posedge clk_sys) begin
    if (stop_issue === 1'b1) begin
      stop_seen <= stop_seen + 1;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rdy();
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
  endtask

  // Single word write: address phase, then data phase
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    hwrite <= 1'b1;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask

  // Single word read, data taken at the data phase edge
  task automatic bus_rd(input logic [7:0] a, input logic dbg,
                        output logic [31:0] d);
    @(posedge clk_sys);
    hsel         <= 1'b1;
    haddr        <= {24'h000000, a};
    hwrite       <= 1'b0;
    htrans       <= 2'h2;
    debug_access <= dbg;
    rdy();
    htrans       <= 2'h0;
    debug_access <= 1'b0;
    rdy();
    d = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic dbg,
                        input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, dbg, d);
    check(d, exp);
    check({31'h0, hresp}, 32'h00000000);
  endtask

  // Load count, start with go, then run one frame on the bus
  task automatic xfer(input logic [4:0] c, input logic [15:0] n,
                      input logic [7:0] b, input logic k);
    bus_wr(`ISF_OFS_COUNT, {16'h0000, n});
    bus_wr(`ISF_OFS_CTRL, {26'h0000000, 1'b1, c});
    repeat (4) @(posedge clk_sys);
    bus_peer.frame(b, k);
    repeat (6) @(posedge clk_sys);
  endtask

  task automatic reset_chk();
    check({31'h00000000, irq}, 32'h00000000);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000000);
    rd_chk(`ISF_OFS_CTRL, 1'b0, 32'h00000000);
    rd_chk(`ISF_OFS_IRQMASK, 1'b0, 32'h00000000);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #200000;
    fail_count++;
    wrap_up();
  end

  initial begin
    reset        = 1'b1;
    hsel         = 1'b0;
    haddr        = 32'h00000000;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hsize        = 3'h2;
    hwdata       = 32'h00000000;
    debug_access = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    reset_chk();
    // Table of ordinary transfers
    foreach (rows[i]) begin
      s0 = stop_seen;
      bus_wr(`ISF_OFS_STATUS, 32'h0000000E);
      xfer(rows[i].ctrl, rows[i].cnt, rows[i].data, rows[i].ackb);
      rd_chk(`ISF_OFS_STATUS, 1'b0, {28'h0, rows[i].stat});
      check(32'(stop_seen - s0), {31'h0, rows[i].stop_request_bit});
    end
    // Writing zero and reading status leave flags alone
    bus_wr(`ISF_OFS_STATUS, 32'h00000000);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000006);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000006);
    // Source register read: emulator keeps, CPU clears the nack flag
    rd_chk(`ISF_OFS_ISRC, 1'b1, {29'h0, `ISF_CODE_NACK});
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000006);
    rd_chk(`ISF_OFS_ISRC, 1'b0, {29'h0, `ISF_CODE_NACK});
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000004);
    bus_wr(`ISF_OFS_STATUS, 32'h00000004);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000000);
    // Acknowledge after a nack clears the flag
    xfer(5'h10, 16'h0001, 8'h55, 1'b1);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000002);
    xfer(5'h10, 16'h0001, 8'hAA, 1'b0);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000000);
    // Holding register: emulator read keeps, CPU read clears
    xfer(5'h00, 16'h0001, 8'h96, 1'b0);
    rd_chk(`ISF_OFS_RXHOLD, 1'b1, 32'h00000096);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000008);
    rd_chk(`ISF_OFS_RXHOLD, 1'b0, 32'h00000096);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000000);
    // Starting a new command clears access ready
    xfer(5'h14, 16'h0001, 8'h42, 1'b0);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000004);
    bus_wr(`ISF_OFS_CTRL, 32'h00000034);
    repeat (3) @(posedge clk_sys);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h00000000);
    // Interrupt masked, then unmasked, then cleared by reading
    bus_rd(`ISF_OFS_IRQST, 1'b0, junk);
    xfer(5'h00, 16'h0001, 8'h21, 1'b0);
    check({31'h0, irq}, 32'h00000000);
    rd_chk(`ISF_OFS_IRQST, 1'b0, 32'h00000008);
    bus_wr(`ISF_OFS_IRQMASK, 32'h00000008);
    rd_chk(`ISF_OFS_IRQMASK, 1'b0, 32'h00000008);
    xfer(5'h00, 16'h0001, 8'h12, 1'b0);
    check({31'h0, irq}, 32'h00000001);
    rd_chk(`ISF_OFS_IRQST, 1'b0, 32'h00000008);
    repeat (2) @(posedge clk_sys);
    check({31'h0, irq}, 32'h00000000);
    // Unmapped offset reads zero and ignores writes
    bus_wr(8'h1C, 32'hFFFFFFFF);
    rd_chk(8'h1C, 1'b0, 32'h00000000);
    // Reset in mid-run clears every flag, nack interrupt unmasked first
    bus_wr(`ISF_OFS_IRQMASK, 32'h0000000A);
    xfer(5'h14, 16'h0001, 8'h77, 1'b1);
    check({31'h0, irq}, 32'h00000001);
    rd_chk(`ISF_OFS_STATUS, 1'b0, 32'h0000000E);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    reset_chk();
    wrap_up();
  end
endmodule
